// *** src/ppm_pkg.sv ***
// Package of constants and types for the power-mode control block
`default_nettype none
package ppm_pkg;
    // Register indices (MDIO register numbers; byte address is not used on this port)
    localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
    localparam logic [4:0] REG_PLL_CTRL = 5'h10;
    localparam logic [4:0] REG_OSC_CTRL = 5'h11;
    localparam logic [4:0] REG_SLEEP_CTRL = 5'h18;
    localparam logic [4:0] REG_PHY_CTRL2 = 5'h1F;
    localparam logic [4:0] REG_POWER_STATUS = 5'h1E;
    // Field positions
    localparam int BIT_SOFT_RESET = 15;
    localparam int BIT_ANEG_EN = 12;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_PLL_OFF = 4;
    localparam int BIT_SLOW_OSC = 5;
    localparam int BIT_SLEEP_DIS = 11;
    localparam int BIT_POWER_SAVE = 10;
    // Reset values of the controlling bits
    localparam logic RST_ANEG_EN = 1'b1;
    localparam logic RST_POWER_DOWN = 1'b0;
    localparam logic RST_PLL_OFF = 1'b0;
    localparam logic RST_SLOW_OSC = 1'b0;
    localparam logic RST_SLEEP_DIS = 1'b1;
    localparam logic RST_POWER_SAVE = 1'b0;
    // Timing
    localparam int CLK_FREQ_MHZ = 25;
    localparam int SOFT_RESET_NS = 200;
    localparam int SOFT_RESET_CYC = (SOFT_RESET_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int PULSE_INTERVAL_US = 16;
    localparam int PULSE_INTERVAL_CYC = PULSE_INTERVAL_US * CLK_FREQ_MHZ;

    typedef enum {
        PM_NORMAL,
        PM_SAVE,
        PM_SLEEP,
        PM_DOWN,
        PM_RESET
    } ppm_state_t;

    // Block enables, one bit per transceiver part
    typedef struct packed {
        logic transmitter;
        logic energyDetect;
        logic pll;
        logic receiver;
        logic digitalCore;
        logic refClockSel;
    } ppm_power_t;
endpackage
`default_nettype wire

// *** src/ppm_phy_power_mode_control.sv ***
// Power-mode control: register port, mode state machine and block enables
//
// Behaviour
// R1: Power-saving bit set enters power saving, only with autoneg on and no link.
// R2: Power saving keeps only transmitter, energy detect and PLL powered.
// R3: Power saving is off after power-up until software sets it.
// R4: Sleep control bit written zero enables energy-detect sleep, autoneg on, no link.
// R5: PLL-off bit stops the PLL in sleep; only transmitter and detect remain.
// R6: Sleep keeps sending periodic link pulses; interval is programmable.
// R7: Energy-detect sleep is disabled at power-up; its bit reads one.
// R8: Power-down bit one disables everything but the management interface; here the crystal input and clock select stay on unless slow-osc is set.
// R9: Clearing the power-down bit leaves power-down.
// R10: Slow-oscillator bit one deselects the crystal input for the slow oscillator.
// R11: Slow oscillator plus power-down is lowest power; registers stay reachable.
// R12: Exit order is clear slow-osc, clear power-down, then software reset.
// R13: Software reset self-clears and restores mode bits to defaults.
`default_nettype none
module ppm_phy_power_mode_control #(
    parameter int PULSE_INTERVAL = ppm_pkg::PULSE_INTERVAL_CYC,
    parameter int RESET_CYCLES = ppm_pkg::SOFT_RESET_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [15:0] regRdData,
    input wire logic linkUp,
    output ppm_pkg::ppm_power_t powerEn,
    output logic crystalInputEn,
    output logic linkPulse,
    output logic softResetBusy
);
    // Room for the widest interval, base shifted by the largest scale of 3
    localparam int PW = $clog2((PULSE_INTERVAL << 3) + 1) + 1;
    localparam int RW = $clog2(RESET_CYCLES + 1) + 1;

    logic anegEn_reg;
    logic powerDown_reg;
    logic pllOff_reg;
    logic slowOsc_reg;
    logic sleepDis_reg;
    logic powerSave_reg;
    logic softReset_reg;
    logic [RW-1:0] resetCnt_reg;
    logic [PW-1:0] pulseCnt_reg;
    logic [1:0] pulseScale_reg;
    ppm_pkg::ppm_state_t state_reg;
    ppm_pkg::ppm_state_t state_next;
    ppm_pkg::ppm_power_t power_next;
    logic resetDone;
    logic [PW-1:0] pulseLimit;

    assign resetDone = softReset_reg && (resetCnt_reg == RW'(RESET_CYCLES));
    // Longer pulse spacing saves more power in sleep [R6]
    assign pulseLimit = PW'(PULSE_INTERVAL) << pulseScale_reg;

    // Mode control bits
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            anegEn_reg <= ppm_pkg::RST_ANEG_EN;
            powerDown_reg <= ppm_pkg::RST_POWER_DOWN;
            pllOff_reg <= ppm_pkg::RST_PLL_OFF;
            slowOsc_reg <= ppm_pkg::RST_SLOW_OSC;
            sleepDis_reg <= ppm_pkg::RST_SLEEP_DIS; // [R7]
            powerSave_reg <= ppm_pkg::RST_POWER_SAVE; // [R3]
            pulseScale_reg <= 2'h0;
        end else if (resetDone) begin
            // Defaults restored at end of soft reset [R13]
            anegEn_reg <= ppm_pkg::RST_ANEG_EN;
            powerDown_reg <= ppm_pkg::RST_POWER_DOWN;
            pllOff_reg <= ppm_pkg::RST_PLL_OFF;
            slowOsc_reg <= ppm_pkg::RST_SLOW_OSC;
            sleepDis_reg <= ppm_pkg::RST_SLEEP_DIS;
            powerSave_reg <= ppm_pkg::RST_POWER_SAVE;
            pulseScale_reg <= 2'h0;
        end else if (regWrStb) begin
            case (regAddr)
                ppm_pkg::REG_BASIC_CTRL: begin
                    anegEn_reg <= regWrData[ppm_pkg::BIT_ANEG_EN];
                    powerDown_reg <= regWrData[ppm_pkg::BIT_POWER_DOWN]; // [R8] [R9]
                end
                ppm_pkg::REG_PLL_CTRL: begin
                    pllOff_reg <= regWrData[ppm_pkg::BIT_PLL_OFF];
                end
                ppm_pkg::REG_OSC_CTRL: begin
                    slowOsc_reg <= regWrData[ppm_pkg::BIT_SLOW_OSC];
                end
                ppm_pkg::REG_SLEEP_CTRL: begin
                    sleepDis_reg <= regWrData[ppm_pkg::BIT_SLEEP_DIS];
                    pulseScale_reg <= regWrData[1:0];
                end
                ppm_pkg::REG_PHY_CTRL2: begin
                    powerSave_reg <= regWrData[ppm_pkg::BIT_POWER_SAVE];
                end
                default: begin
                end
            endcase
        end
    end

    // Software reset bit and its duration counter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            softReset_reg <= 1'b0;
            resetCnt_reg <= '0;
        end else if (softReset_reg) begin
            resetCnt_reg <= resetCnt_reg + RW'(1);
            if (resetDone) begin
                softReset_reg <= 1'b0; // [R13]
                resetCnt_reg <= '0;
            end
        end else if (regWrStb && regAddr == ppm_pkg::REG_BASIC_CTRL && regWrData[ppm_pkg::BIT_SOFT_RESET]) begin
            // Final exit step after slow-osc and power-down are cleared [R12]
            softReset_reg <= 1'b1;
        end
    end

    // Mode selection; soft reset dominates, then power-down, then sleep, then power saving
    always_comb begin
        state_next = ppm_pkg::PM_NORMAL;
        if (softReset_reg) begin
            state_next = ppm_pkg::PM_RESET;
        end else if (powerDown_reg) begin
            state_next = ppm_pkg::PM_DOWN; // [R8]
        end else if (!sleepDis_reg && anegEn_reg && !linkUp) begin
            state_next = ppm_pkg::PM_SLEEP; // [R4]
        end else if (powerSave_reg && anegEn_reg && !linkUp) begin
            state_next = ppm_pkg::PM_SAVE; // [R1]
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ppm_pkg::PM_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // Block enables per mode
    always_comb begin
        power_next = '1;
        case (state_next)
            ppm_pkg::PM_NORMAL: begin
                power_next = '1;
            end
            ppm_pkg::PM_SAVE: begin
                power_next.receiver = 1'b0; // [R2]
                power_next.digitalCore = 1'b0;
            end
            ppm_pkg::PM_SLEEP: begin
                power_next.receiver = 1'b0;
                power_next.digitalCore = 1'b0;
                power_next.pll = !pllOff_reg; // [R5]
            end
            ppm_pkg::PM_DOWN, ppm_pkg::PM_RESET: begin
                power_next = '0; // [R8]
            end
            default: begin
                power_next = '1;
            end
        endcase
        // Slow oscillator replaces the crystal input [R10] [R11]
        power_next.refClockSel = !slowOsc_reg;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            powerEn <= '1;
            crystalInputEn <= 1'b1;
            softResetBusy <= 1'b0;
        end else begin
            powerEn <= power_next;
            crystalInputEn <= !slowOsc_reg; // [R10]
            softResetBusy <= softReset_reg;
        end
    end

    // Link pulse generator, aligned with the enables of the same mode
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pulseCnt_reg <= '0;
            linkPulse <= 1'b0;
        end else if (state_next == ppm_pkg::PM_SLEEP) begin
            linkPulse <= 1'b0;
            if (pulseCnt_reg >= pulseLimit - PW'(1)) begin
                pulseCnt_reg <= '0;
                linkPulse <= 1'b1; // [R6]
            end else begin
                pulseCnt_reg <= pulseCnt_reg + PW'(1);
            end
        end else begin
            pulseCnt_reg <= '0;
            linkPulse <= 1'b0;
        end
    end

    // Read port stays alive in every mode [R11]
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= 16'h0000;
        end else if (regRdStb) begin
            regRdData <= 16'h0000;
            case (regAddr)
                ppm_pkg::REG_BASIC_CTRL: begin
                    regRdData[ppm_pkg::BIT_SOFT_RESET] <= softReset_reg;
                    regRdData[ppm_pkg::BIT_ANEG_EN] <= anegEn_reg;
                    regRdData[ppm_pkg::BIT_POWER_DOWN] <= powerDown_reg;
                end
                ppm_pkg::REG_PLL_CTRL: begin
                    regRdData[ppm_pkg::BIT_PLL_OFF] <= pllOff_reg;
                end
                ppm_pkg::REG_OSC_CTRL: begin
                    regRdData[ppm_pkg::BIT_SLOW_OSC] <= slowOsc_reg;
                end
                ppm_pkg::REG_SLEEP_CTRL: begin
                    regRdData[ppm_pkg::BIT_SLEEP_DIS] <= sleepDis_reg;
                    regRdData[1:0] <= pulseScale_reg;
                end
                ppm_pkg::REG_PHY_CTRL2: begin
                    regRdData[ppm_pkg::BIT_POWER_SAVE] <= powerSave_reg;
                end
                ppm_pkg::REG_POWER_STATUS: begin
                    regRdData[2:0] <= 3'(state_reg);
                end
                default: begin
                end
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// *** verif/ppm_ctrl_asserts.sv ***
// Port checker for the power-mode control block
`default_nettype none
module ppm_ctrl_asserts #(parameter int RESET_CYCLES = 2) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic regRdStb,
    input wire logic [15:0] regRdData,
    input wire logic linkUp,
    input wire ppm_pkg::ppm_power_t powerEn,
    input wire logic crystalInputEn,
    input wire logic linkPulse,
    input wire logic softResetBusy
);
    int busyCnt;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busyCnt <= 0;
        end else begin
            busyCnt <= softResetBusy ? busyCnt + 1 : 0;
        end
    end
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    rd_idle_zero_a: assert property (!$past(regRdStb) |-> regRdData == 16'h0000)
        else $error("read data seen outside its cycle");
    pulse_single_a: assert property (linkPulse |=> !linkPulse)
        else $error("link pulse longer than one cycle");
    pulse_sleep_a: assert property (linkPulse |-> powerEn.transmitter && !powerEn.receiver)
        else $error("link pulse outside sleep");
    osc_select_a: assert property (powerEn.refClockSel == crystalInputEn)
        else $error("clock select and crystal enable differ");
    down_all_off_a: assert property (!powerEn.transmitter |-> powerEn[4:1] == 4'h0)
        else $error("block left on in power-down");
    save_keeps_a: assert property (!powerEn.receiver && powerEn.transmitter |-> powerEn.energyDetect)
        else $error("energy detect off in low power");
    rx_pair_a: assert property (powerEn.receiver == powerEn.digitalCore)
        else $error("receiver and core enables differ");
    link_wake_a: assert property (linkUp [*3] ##0 powerEn.transmitter |-> powerEn.receiver)
        else $error("low power held with link present");
    busy_len_a: assert property ($fell(softResetBusy) |-> busyCnt == RESET_CYCLES + 1)
        else $error("soft reset length wrong");
    cover property (linkPulse);
    cover property ($fell(softResetBusy));
    cover property (!crystalInputEn && !powerEn.transmitter);
endmodule
bind ppm_phy_power_mode_control ppm_ctrl_asserts #(.RESET_CYCLES(RESET_CYCLES)) chk (.sys_clk, .arst_n,
    .regRdStb, .regRdData, .linkUp, .powerEn, .crystalInputEn, .linkPulse, .softResetBusy);
`default_nettype wire

// *** verif/ppm_mgmt_model.sv ***
// Management controller model on the register port
`default_nettype none
module ppm_mgmt_model (
    input wire logic sys_clk,
    output logic [4:0] regAddr,
    output logic [15:0] regWrData,
    output logic regWrStb,
    output logic regRdStb,
    input wire logic [15:0] regRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        regAddr = 5'h1F;
        regWrData = 16'hFFFF;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
    end
    // Released lines show inverted values
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask
    // Reads allowed in every power state
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        regAddr <= ~a;
        @(posedge sys_clk);
        d = regRdData;
    endtask
endmodule
`default_nettype wire

// *** verif/tb_phy_power_mode_control.sv ***
// Self-checking bench for the power-mode control block
`default_nettype none
module tb_phy_power_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic linkUp = 1'b0;
    logic [4:0] regAddr;
    logic [15:0] regWrData, regRdData, rdv;
    logic regWrStb, regRdStb, crystalInputEn, linkPulse, softResetBusy;
    ppm_pkg::ppm_power_t powerEn;
    logic [7:0] lfsr = 8'h1C;
    int n_fail = 0;
    int cmp_count = 0;
    int cnt;
    always #20 sys_clk = ~sys_clk;
    ppm_phy_power_mode_control #(.PULSE_INTERVAL(8), .RESET_CYCLES(2)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .linkUp(linkUp), .powerEn(powerEn), .crystalInputEn(crystalInputEn),
        .linkPulse(linkPulse), .softResetBusy(softResetBusy));
    ppm_mgmt_model mgmt (.sys_clk(sys_clk), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData));
    function automatic logic [7:0] lfsr_next(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [15:0] exp_def(input logic [4:0] a);
        return a == 5'h00 ? 16'h1000 : a == 5'h18 ? 16'h0800 : 16'h0000;
    endfunction
    // Enables, then crystal select
    function automatic logic [6:0] pwr(input logic tx, ed, pll, rx, slow);
        return {tx, ed, pll, rx, rx, ~slow, ~slow};
    endfunction
    task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pwr(input string n, input logic [6:0] e);
        repeat (3) @(posedge sys_clk);
        chk_reg(n, {9'h000, e}, {9'h000, powerEn, crystalInputEn});
    endtask
    task automatic all_regs();
        for (int a = 0; a < 32; a++) begin
            mgmt.rd(5'(a), rdv);
            chk_reg("register", exp_def(5'(a)), rdv);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100us;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        chk_pwr("reset", pwr(1, 1, 1, 1, 0));
        all_regs();
        mgmt.wr(5'h1F, 16'h0400);
        chk_pwr("save", pwr(1, 1, 1, 0, 0));
        linkUp <= 1'b1;
        chk_pwr("linked", pwr(1, 1, 1, 1, 0));
        linkUp <= 1'b0;
        mgmt.wr(5'h18, 16'h0000);
        chk_pwr("sleep", pwr(1, 1, 1, 0, 0));
        cnt = 0;
        repeat (80) @(posedge sys_clk) cnt += (linkPulse === 1'b1);
        chk_reg("pulses", 16'd10, 16'(cnt));
        mgmt.wr(5'h18, 16'h0001);
        cnt = 0;
        repeat (80) @(posedge sys_clk) cnt += (linkPulse === 1'b1);
        chk_reg("scaled pulses", 16'd5, 16'(cnt));
        mgmt.wr(5'h10, 16'h0010);
        chk_pwr("pll off", pwr(1, 1, 0, 0, 0));
        mgmt.wr(5'h00, 16'h1800);
        chk_pwr("down", pwr(0, 0, 0, 0, 0));
        mgmt.wr(5'h11, 16'h0020);
        chk_pwr("slow", pwr(0, 0, 0, 0, 1));
        mgmt.rd(5'h11, rdv);
        chk_reg("slow bit", 16'h0020, rdv);
        mgmt.wr(5'h11, 16'h0000);
        mgmt.wr(5'h00, 16'h1000);
        chk_pwr("wake", pwr(1, 1, 0, 0, 0));
        mgmt.wr(5'h00, 16'h9000);
        cnt = 0;
        repeat (12) @(posedge sys_clk) cnt += (softResetBusy === 1'b1);
        chk_reg("busy", 16'd3, 16'(cnt));
        chk_pwr("defaults", pwr(1, 1, 1, 1, 0));
        all_regs();
        repeat (16) begin
            lfsr = lfsr_next(lfsr);
            linkUp <= lfsr[0];
            mgmt.rd(lfsr[5:1], rdv);
            chk_reg("random", exp_def(lfsr[5:1]), rdv);
        end
        final_report();
    end
endmodule
`default_nettype wire
